// ==== hw_strap_mode_config.sv ====
`timescale 1ns/10ps
module hw_strap_mode_config (
	input wire logic core_clk_i,
	input wire logic arst_n_i,
	input wire logic switch_freq_select_pin_i,
	input wire logic bridge_mode_select_pin_i,
	input wire logic output_sleep_pin_i,
	input wire logic [1:0] gain_code_pins_i,
	input wire logic shutdown_pin_n_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	output logic sw_control_mode_o,
	output logic ctrl_port_en_o,
	output logic ctrl_scl_o,
	output logic ctrl_sda_o,
	output logic [4:0] pwm_rate_mult_o,
	output logic parallel_output_mode_o,
	output logic parallel_left_slot_o,
	output logic [1:0] analog_gain_code_o,
	output logic [7:0] analog_gain_cdbv_o,
	output logic [3:0] digital_gain_db_o,
	output logic [7:0] volume_db_o,
	output logic audio_mute_o,
	output logic output_switching_o,
	output logic outputs_hiz_o,
	output logic signal_path_en_o,
	output logic shutdown_o
);
	import strap_cfg_pkg::*;

	localparam int A_DRAIN_MAX = DRAIN_CYCLES;

	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!arst_n_i);

	cfg_pins_if pins_bus ();

	logic [7:0] ctrl_reg;
	logic [7:0] gain_reg;
	logic [7:0] volume_reg;
	logic cfg_changed;
	amp_state_t state;
	logic [SEQ_CNT_W-1:0] seq_cnt;
	logic from_shut;
	logic sw_now;
	logic sleep_req;
	logic shut;
	logic [SEQ_CNT_W-1:0] wake_last;

	// ==========================================================
	// Pin capture
	assign pins_bus.raw.freq = switch_freq_select_pin_i;
	assign pins_bus.raw.bridge = bridge_mode_select_pin_i;
	assign pins_bus.raw.sleep = output_sleep_pin_i;
	assign pins_bus.raw.gain = gain_code_pins_i;
	assign pins_bus.raw.shutdown_n = shutdown_pin_n_i;

	pin_settle_filter u_settle (
		.core_clk_i(core_clk_i),
		.arst_n_i(arst_n_i),
		.pins(pins_bus)
	);

	function automatic logic [7:0] analog_cdbv(input logic [1:0] code);
		case (code)
			2'h0: analog_cdbv = GAIN_CDBV_00;
			2'h1: analog_cdbv = GAIN_CDBV_01;
			default: analog_cdbv = GAIN_CDBV_10;
		endcase
	endfunction

	// ==========================================================
	// Mode selection
	assign sw_now = (pins_bus.stable.gain == GAIN_SW_CODE);
	assign shut = !pins_bus.stable.shutdown_n;
	assign sleep_req = sw_now ? ctrl_reg[CTRL_SLEEP_BIT] : pins_bus.stable.sleep;
	assign wake_last = from_shut ? SEQ_CNT_W'(POWERUP_CYCLES - 1)
		: SEQ_CNT_W'(WAKE_CYCLES - 1);

	// ==========================================================
	// Register writes
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ctrl_reg <= CTRL_RESET;
			gain_reg <= GAIN_RESET;
			volume_reg <= VOLUME_RESET;
		end else if (reg_wr_i) begin
			if (reg_addr_i == REG_CTRL) begin
				ctrl_reg <= reg_wdata_i[7:0];
			end else if (reg_addr_i == REG_GAIN) begin
				gain_reg <= reg_wdata_i[7:0];
			end else if (reg_addr_i == REG_VOLUME) begin
				volume_reg <= reg_wdata_i[7:0];
			end
		end
	end

	// A new settled pin pattern outranks a clear in the same cycle.
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cfg_changed <= 1'b0;
		end else if (pins_bus.changed) begin
			cfg_changed <= 1'b1;
		end else if (reg_wr_i && reg_addr_i == REG_STATUS
			&& reg_wdata_i[STAT_CHANGED_BIT]) begin
			cfg_changed <= 1'b0;
		end
	end

	// ==========================================================
	// Register reads
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			reg_rdata_o <= 32'h0000_0000;
		end else if (!reg_rd_i) begin
			reg_rdata_o <= 32'h0000_0000;
		end else if (reg_addr_i == REG_CTRL) begin
			reg_rdata_o <= {24'h00_0000, ctrl_reg};
		end else if (reg_addr_i == REG_GAIN) begin
			reg_rdata_o <= {24'h00_0000, gain_reg};
		end else if (reg_addr_i == REG_VOLUME) begin
			reg_rdata_o <= {24'h00_0000, volume_reg};
		end else if (reg_addr_i == REG_STATUS) begin
			reg_rdata_o <= {24'h00_0000, cfg_changed, analog_gain_code_o, shutdown_o,
				state, parallel_output_mode_o, sw_control_mode_o};
		end else begin
			reg_rdata_o <= 32'h0000_0000;
		end
	end

	// ==========================================================
	// Configuration decode
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sw_control_mode_o <= 1'b0;
			pwm_rate_mult_o <= MULT_16;
			parallel_output_mode_o <= 1'b0;
			parallel_left_slot_o <= 1'b0;
			analog_gain_code_o <= 2'h0;
			analog_gain_cdbv_o <= GAIN_CDBV_00;
			digital_gain_db_o <= BOOST_DB;
			volume_db_o <= VOL_DEFAULT;
		end else if (sw_now) begin
			sw_control_mode_o <= 1'b1;
			pwm_rate_mult_o <= ctrl_reg[CTRL_FREQ_BIT] ? MULT_8 : MULT_16;
			parallel_output_mode_o <= ctrl_reg[CTRL_PAR_BIT];
			parallel_left_slot_o <= ctrl_reg[CTRL_PAR_BIT] & ctrl_reg[CTRL_LEFT_BIT];
			analog_gain_code_o <= gain_reg[1:0];
			analog_gain_cdbv_o <= analog_cdbv(gain_reg[1:0]);
			digital_gain_db_o <= gain_reg[7:4];
			volume_db_o <= volume_reg;
		end else begin
			sw_control_mode_o <= 1'b0;
			pwm_rate_mult_o <= pins_bus.stable.freq ? MULT_8 : MULT_16;
			parallel_output_mode_o <= pins_bus.stable.bridge;
			// Only the right slot feeds the parallel stage here; a sender wanting
			// left audio swaps its word-select phase instead.
			parallel_left_slot_o <= 1'b0;
			analog_gain_code_o <= pins_bus.stable.gain;
			analog_gain_cdbv_o <= analog_cdbv(pins_bus.stable.gain);
			digital_gain_db_o <= BOOST_DB;
			volume_db_o <= VOL_DEFAULT;
		end
	end

	// The control port lines pass through the settle filter, which also acts
	// as its spike filter; they idle high while hardware mode owns the pins.
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ctrl_port_en_o <= 1'b0;
			ctrl_scl_o <= 1'b1;
			ctrl_sda_o <= 1'b1;
		end else begin
			ctrl_port_en_o <= sw_now;
			ctrl_scl_o <= sw_now ? pins_bus.stable.bridge : 1'b1;
			ctrl_sda_o <= sw_now ? pins_bus.stable.freq : 1'b1;
		end
	end

	// ==========================================================
	// Output stage sequencer
	// Sleep drains through a muted ramp before switching stops; shutdown cuts
	// at once and, because the path went down, its exit takes the long start.
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state <= ST_SLEEP;
			seq_cnt <= '0;
			from_shut <= 1'b1;
		end else begin
			case (state)
				ST_RUN: begin
					if (shut) begin
						state <= ST_SLEEP;
						from_shut <= 1'b1;
					end else if (sleep_req) begin
						state <= ST_DRAIN;
						seq_cnt <= '0;
					end
				end
				ST_DRAIN: begin
					if (shut) begin
						state <= ST_SLEEP;
						from_shut <= 1'b1;
					end else if (seq_cnt == SEQ_CNT_W'(DRAIN_CYCLES - 1)) begin
						state <= ST_SLEEP;
					end else begin
						seq_cnt <= seq_cnt + 1'b1;
					end
				end
				ST_SLEEP: begin
					if (shut) begin
						from_shut <= 1'b1;
					end else if (!sleep_req) begin
						state <= ST_WAKE;
						seq_cnt <= '0;
					end
				end
				default: begin
					if (shut) begin
						state <= ST_SLEEP;
						from_shut <= 1'b1;
					end else if (sleep_req) begin
						state <= ST_DRAIN;
						seq_cnt <= '0;
					end else if (seq_cnt == wake_last) begin
						state <= ST_RUN;
						from_shut <= 1'b0;
					end else begin
						seq_cnt <= seq_cnt + 1'b1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			audio_mute_o <= 1'b1;
			output_switching_o <= 1'b0;
			outputs_hiz_o <= 1'b1;
			signal_path_en_o <= 1'b0;
			shutdown_o <= 1'b1;
		end else begin
			audio_mute_o <= (state != ST_RUN);
			output_switching_o <= (state != ST_SLEEP);
			outputs_hiz_o <= (state == ST_SLEEP);
			signal_path_en_o <= !shut;
			shutdown_o <= shut;
		end
	end

	// ==========================================================
	// Checks
	sequence s_sleep_asked;
		state == ST_RUN && sleep_req && !shut;
	endsequence

	sequence s_drain_to_sleep;
		state == ST_DRAIN ##[1:A_DRAIN_MAX] state == ST_SLEEP;
	endsequence

	property p_graceful_sleep;
		s_sleep_asked |=> s_drain_to_sleep ##1 (outputs_hiz_o && !output_switching_o);
	endproperty

	a_freq_low_16x: assert property (!sw_now && !pins_bus.stable.freq
		|=> pwm_rate_mult_o == MULT_16)
		else $error("frequency pin low did not select 16x");

	a_freq_high_8x: assert property (!sw_now && pins_bus.stable.freq
		|=> pwm_rate_mult_o == MULT_8)
		else $error("frequency pin high did not select 8x");

	a_bridge_parallel: assert property (!sw_now && pins_bus.stable.bridge
		|=> parallel_output_mode_o)
		else $error("bridge pin high did not select parallel output");

	a_bridge_normal: assert property (!sw_now && !pins_bus.stable.bridge
		|=> !parallel_output_mode_o)
		else $error("bridge pin low did not select two-channel output");

	a_right_slot: assert property (!sw_now |=> !parallel_left_slot_o)
		else $error("hardware parallel mode took the left slot");

	a_sleep_graceful: assert property (p_graceful_sleep)
		else $error("sleep did not drain to high impedance in time");

	a_path_alive: assert property (state == ST_SLEEP && !shut
		|=> signal_path_en_o && !shutdown_o)
		else $error("signal path stopped during sleep");

	a_quick_wake: assert property (state == ST_WAKE && !from_shut
		|-> seq_cnt < SEQ_CNT_W'(WAKE_CYCLES))
		else $error("wake from sleep took the shutdown start");

	a_gain_codes: assert property (!sw_now
		|=> analog_gain_code_o == $past(pins_bus.stable.gain)
		&& (analog_gain_code_o != 2'h0 || analog_gain_cdbv_o == GAIN_CDBV_00)
		&& (analog_gain_code_o != 2'h2 || analog_gain_cdbv_o == GAIN_CDBV_10))
		else $error("hardware gain code decoded wrongly");

	a_boost_fixed: assert property (!sw_now && pins_bus.stable.gain == 2'h1
		|=> digital_gain_db_o == BOOST_DB && analog_gain_cdbv_o == GAIN_CDBV_01)
		else $error("hardware gain pairing wrong");

	a_sw_entry: assert property (sw_now
		|=> sw_control_mode_o && analog_gain_code_o == $past(gain_reg[1:0]))
		else $error("gain code 11 did not enter software mode");

	a_volume_fixed: assert property (!sw_now |=> volume_db_o == VOL_DEFAULT)
		else $error("hardware mode volume moved");

	a_port_handoff: assert property (sw_now
		|=> ctrl_port_en_o && ctrl_scl_o == $past(pins_bus.stable.bridge)
		&& ctrl_sda_o == $past(pins_bus.stable.freq))
		else $error("control port did not take over the pins");

	a_shutdown_now: assert property (shut
		|=> state == ST_SLEEP && shutdown_o && !signal_path_en_o
		##1 outputs_hiz_o)
		else $error("shutdown pin low did not shut down");

endmodule // hw_strap_mode_config

// ==== strap_cfg_pkg.sv ====
// What this block does
// - Hardware mode: frequency pin low gives switching at sixteen times sample rate.
// - Hardware mode: frequency pin high gives switching at eight times sample rate.
// - Hardware mode: bridge pin high drives one speaker with both channels parallel.
// - Hardware mode: bridge pin low gives ordinary two-channel bridge-tied output.
// - Parallel mode under hardware control takes its input from the right slot.
// - Hardware mode: sleep pin high gracefully stops switching, outputs go high impedance.
// - Signal path keeps running in sleep so waking beats leaving shutdown.
// - Gain codes 00, 01, 10 select rising analog gain in that order.
// - Digital boost stays +6 dB in hardware mode; analog gain 19.2, 22.6, 25 dBV per code.
// - Gain code 11 leaves hardware control for software control mode.
// - Hardware mode keeps digital volume fixed at its 0 dB default.
// - Software mode hands bridge and frequency pins to control port clock and data.
// - Shutdown pin low forces lowest-power shutdown in either mode; high releases.
package strap_cfg_pkg;

	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int FILTER_TIME_NS = 100;
	localparam int DRAIN_TIME_NS = 2000;
	localparam int WAKE_TIME_NS = 1000;
	localparam int POWERUP_TIME_NS = 10000;
	localparam int FILTER_CYCLES = (FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DRAIN_CYCLES = (DRAIN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WAKE_CYCLES = (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int POWERUP_CYCLES = (POWERUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FILT_CNT_W = 4;
	localparam int SEQ_CNT_W = 10;

	// ==========================================================
	// Configuration pins
	localparam int PIN_COUNT = 6;
	typedef struct packed {
		logic shutdown_n;
		logic [1:0] gain;
		logic sleep;
		logic bridge;
		logic freq;
	} pins_t;
	localparam pins_t PINS_RESET = 6'h00;
	localparam logic [1:0] GAIN_SW_CODE = 2'h3;

	// ==========================================================
	// Decoded settings
	localparam logic [4:0] MULT_16 = 5'h10;
	localparam logic [4:0] MULT_8 = 5'h08;
	localparam logic [7:0] GAIN_CDBV_00 = 8'hC0;
	localparam logic [7:0] GAIN_CDBV_01 = 8'hE2;
	localparam logic [7:0] GAIN_CDBV_10 = 8'hFA;
	localparam logic [3:0] BOOST_DB = 4'h6;
	localparam logic [7:0] VOL_DEFAULT = 8'h00;

	// ==========================================================
	// Register map
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_GAIN = 8'h04;
	localparam logic [7:0] REG_VOLUME = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] GAIN_RESET = 8'h60;
	localparam logic [7:0] VOLUME_RESET = 8'h00;
	localparam int CTRL_FREQ_BIT = 0;
	localparam int CTRL_PAR_BIT = 1;
	localparam int CTRL_LEFT_BIT = 2;
	localparam int CTRL_SLEEP_BIT = 3;
	localparam int STAT_CHANGED_BIT = 7;

	// ==========================================================
	// Output stage sequencer
	typedef enum logic [1:0] {
		ST_RUN = 2'h0,
		ST_DRAIN = 2'h1,
		ST_SLEEP = 2'h3,
		ST_WAKE = 2'h2
	} amp_state_t;

endpackage

// ==== cfg_pins_if.sv ====
`timescale 1ns/10ps
interface cfg_pins_if;
	import strap_cfg_pkg::*;
	pins_t raw;
	pins_t stable;
	logic changed;
	modport filt (input raw, output stable, output changed);
	modport core (output raw, input stable, input changed);
endinterface

// ==== pin_settle_filter.sv ====
`timescale 1ns/10ps
module pin_settle_filter (
	input wire logic core_clk_i,
	input wire logic arst_n_i,
	cfg_pins_if.filt pins
);
	import strap_cfg_pkg::*;

	logic [PIN_COUNT-1:0] sync_a;
	logic [PIN_COUNT-1:0] sync_b;
	logic [PIN_COUNT-1:0] sync_prev;
	logic [FILT_CNT_W-1:0] settle_cnt;

	// ==========================================================
	// Two-stage synchronisers
	genvar g;
	generate
		for (g = 0; g < PIN_COUNT; g++) begin : g_sync
			always_ff @(posedge core_clk_i or negedge arst_n_i) begin
				if (!arst_n_i) begin
					sync_a[g] <= PINS_RESET[g];
					sync_b[g] <= PINS_RESET[g];
				end else begin
					sync_a[g] <= pins.raw[g];
					sync_b[g] <= sync_a[g];
				end
			end
		end
	endgenerate

	// ==========================================================
	// Settle: the whole vector must hold still before it is taken, so a
	// pin pair that moves on different edges never shows a mixed code.
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sync_prev <= PINS_RESET;
			settle_cnt <= '0;
			pins.stable <= PINS_RESET;
			pins.changed <= 1'b0;
		end else begin
			sync_prev <= sync_b;
			pins.changed <= 1'b0;
			if (sync_b != sync_prev || sync_b == pins.stable) begin
				settle_cnt <= '0;
			end else if (settle_cnt == FILT_CNT_W'(FILTER_CYCLES - 1)) begin
				pins.stable <= sync_b;
				pins.changed <= 1'b1;
				settle_cnt <= '0;
			end else begin
				settle_cnt <= settle_cnt + 1'b1;
			end
		end
	end

	a_settle_hold: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		!$stable(pins.stable) |-> ($past(sync_b) == pins.stable
			&& $past(sync_b, 5) == pins.stable))
		else $error("settled pins changed without a quiet input");

endmodule // pin_settle_filter

// ==== strap_board_model.sv ====
`timescale 1ns/10ps
// ==========================================================
// Board side of the strap pins: a host that drives levels.
module strap_board_model #(
	parameter int LEAD_CYCLES = 110
) (
	input wire logic core_clk_i,
	input wire strap_cfg_pkg::pins_t want_i,
	output strap_cfg_pkg::pins_t pins_o
);
	import strap_cfg_pkg::*;

	int lead = 0;

	initial pins_o = PINS_RESET;

	// A careful host never drops shutdown straight from normal play.
	// It raises sleep first and holds it long enough for the drain to end.
	always @(posedge core_clk_i) begin
		if (!want_i.shutdown_n && pins_o.shutdown_n && lead != LEAD_CYCLES) begin
			pins_o.sleep <= 1'b1;
			lead <= lead + 1;
		end else begin
			pins_o <= want_i;
			lead <= 0;
		end
	end
endmodule // strap_board_model

// ==== hw_strap_mode_config_tb.sv ====
`timescale 1ns/10ps
module hw_strap_mode_config_tb;
	import strap_cfg_pkg::*;

	typedef struct {
		pins_t pins;
		logic [4:0] mult;
		logic par;
		logic [7:0] cdbv;
	} row_t;

	logic core_clk = 1'b0;
	logic arst_n = 1'b0;
	pins_t want = 6'h20;
	pins_t pins;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h00000000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] rdata;
	logic sw_mode, port_en, scl, sda, par, left, mute, sw_on, hiz, path_en, shut;
	logic [4:0] mult;
	logic [1:0] gcode;
	logic [7:0] cdbv, vol;
	logic [3:0] dig;
	int miscompares = 0;
	int checks = 0;
	row_t rows [6];

	always #10 core_clk = ~core_clk;

	strap_board_model strap_board_model_i (
		.core_clk_i(core_clk),
		.want_i(want),
		.pins_o(pins)
	);

	hw_strap_mode_config hw_strap_mode_config_i (
		.core_clk_i(core_clk),
		.arst_n_i(arst_n),
		.switch_freq_select_pin_i(pins.freq),
		.bridge_mode_select_pin_i(pins.bridge),
		.output_sleep_pin_i(pins.sleep),
		.gain_code_pins_i(pins.gain),
		.shutdown_pin_n_i(pins.shutdown_n),
		.reg_addr_i(reg_addr),
		.reg_wdata_i(reg_wdata),
		.reg_wr_i(reg_wr),
		.reg_rd_i(reg_rd),
		.reg_rdata_o(rdata),
		.sw_control_mode_o(sw_mode),
		.ctrl_port_en_o(port_en),
		.ctrl_scl_o(scl),
		.ctrl_sda_o(sda),
		.pwm_rate_mult_o(mult),
		.parallel_output_mode_o(par),
		.parallel_left_slot_o(left),
		.analog_gain_code_o(gcode),
		.analog_gain_cdbv_o(cdbv),
		.digital_gain_db_o(dig),
		.volume_db_o(vol),
		.audio_mute_o(mute),
		.output_switching_o(sw_on),
		.outputs_hiz_o(hiz),
		.signal_path_en_o(path_en),
		.shutdown_o(shut)
	);

	// ==========================================================
	// Helpers
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	task chk1(input logic seen, input logic exp);
		chk({31'h0, seen}, {31'h0, exp});
	endtask

	task tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	// Pins settle after about ten edges, so twenty leaves a margin.
	task pin(input pins_t p, input int n);
		want = p;
		tick(n);
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		chk(rdata & m, e);
	endtask

	task summarize();
		$display("checks %0d, miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	initial begin
		#400000;
		miscompares++;
		summarize();
	end

	// ==========================================================
	// Main sequence
	initial begin
		rows = '{'{6'h20, MULT_16, 1'b0, GAIN_CDBV_00}, '{6'h21, MULT_8, 1'b0, GAIN_CDBV_00},
			'{6'h2A, MULT_16, 1'b1, GAIN_CDBV_01}, '{6'h2B, MULT_8, 1'b1, GAIN_CDBV_01},
			'{6'h31, MULT_8, 1'b0, GAIN_CDBV_10}, '{6'h32, MULT_16, 1'b1, GAIN_CDBV_10}};
		// Reset only lands at the first edge, since the line starts low.
		tick(1);
		chk1(shut, 1'b1);
		chk1(hiz, 1'b1);
		chk(32'(rdata), 32'h0);
		@(posedge core_clk);
		arst_n <= 1'b1;
		tick(560);
		chk1(shut, 1'b0);
		chk1(mute, 1'b0);
		chk1(sw_on, 1'b1);
		foreach (rows[i]) begin
			pin(rows[i].pins, 20);
			chk(32'(mult), 32'(rows[i].mult));
			chk1(par, rows[i].par);
			chk(32'(gcode), 32'(rows[i].pins.gain));
			chk(32'(cdbv), 32'(rows[i].cdbv));
			chk(32'(dig), 32'(BOOST_DB));
			chk(32'(vol), 32'(VOL_DEFAULT));
			chk1(left, 1'b0);
			chk1(sw_mode, 1'b0);
		end
		// A short glitch on a strap must never reach the decode.
		pin(6'h20, 20);
		want = 6'h21;
		for (int i = 0; i < 24; i++) begin
			if (i == 3) want = 6'h20;
			tick(1);
			chk(32'(mult), 32'(MULT_16));
		end
		pin(6'h24, 15);
		chk1(mute, 1'b1);
		chk1(sw_on, 1'b1);
		tick(115);
		chk1(sw_on, 1'b0);
		chk1(hiz, 1'b1);
		chk1(path_en, 1'b1);
		pin(6'h20, 70);
		chk1(mute, 1'b0);
		chk1(hiz, 1'b0);
		pin(6'h3A, 20);
		chk1(sw_mode, 1'b1);
		chk1(port_en, 1'b1);
		chk1(scl, 1'b1);
		chk1(sda, 1'b0);
		pin(6'h39, 20);
		chk1(scl, 1'b0);
		chk1(sda, 1'b1);
		chk(32'(mult), 32'(MULT_16));
		rd(REG_GAIN, 32'(GAIN_RESET), 32'hFFFFFFFF);
		rd(8'h10, 32'h0, 32'hFFFFFFFF);
		wr(REG_CTRL, 32'h07);
		wr(REG_GAIN, 32'h62);
		wr(REG_VOLUME, 32'h05);
		rd(REG_STATUS, 32'hC3, 32'hFFFFFFFF);
		tick(1);
		chk(rdata, 32'h0);
		// The sticky change flag must clear on a write of one.
		wr(REG_STATUS, 32'h80);
		rd(REG_STATUS, 32'h43, 32'hFFFFFFFF);
		chk(32'(mult), 32'(MULT_8));
		chk1(left, 1'b1);
		chk(32'(cdbv), 32'(GAIN_CDBV_10));
		chk(32'(vol), 32'h5);
		// In software mode sleep comes from the control register, not the pin.
		wr(REG_CTRL, 32'h0F);
		tick(110);
		chk1(sw_on, 1'b0);
		chk1(hiz, 1'b1);
		wr(REG_CTRL, 32'h07);
		tick(60);
		chk1(mute, 1'b0);
		pin(6'h2A, 20);
		chk(32'(vol), 32'(VOL_DEFAULT));
		chk1(left, 1'b0);
		chk1(par, 1'b1);
		chk(32'(mult), 32'(MULT_16));
		pin(6'h00, 150);
		chk1(shut, 1'b1);
		chk1(path_en, 1'b0);
		chk1(hiz, 1'b1);
		pin(6'h20, 80);
		chk1(mute, 1'b1);
		tick(460);
		chk1(mute, 1'b0);
		chk1(shut, 1'b0);
		// A mid-run reset must drop every setting and start from power-up.
		@(posedge core_clk);
		arst_n <= 1'b0;
		tick(1);
		chk1(shut, 1'b1);
		chk1(path_en, 1'b0);
		@(posedge core_clk);
		arst_n <= 1'b1;
		tick(530);
		chk1(sw_on, 1'b1);
		chk1(mute, 1'b0);
		summarize();
	end
endmodule // hw_strap_mode_config_tb
